// ===== shared/flash_host_pkg.sv
// Constants, register map and types for the flash bus controller.
// Assumes a 100 MHz clock and an x16 flash with a 19-bit word address.
// Rules from the document
// [RL1] In identification mode the flash drives the selected code on the low data byte.
// [RL2] Hold the identification voltage on the address pin throughout a strapped read.
// [RL3] Strapped read: bit six low, bits one and zero select the code.
// [RL4] Protection query: sector on high address bits; answer 01h protected, 00h unprotected.
// [RL5] Codes are also readable in-system after the command, without elevated voltage.
// [RL6] A protected sector refuses program and erase; unprotecting allows both again.
// [RL7] Software protects every unprotected sector before the first unprotect write.
// [RL8] All sectors leave the factory unprotected.
// [RL9] Strobe pulses under 5 ns must not start a write cycle.
// [RL10] Write only with chip-select and write strobe low and output-enable high.
// [RL11] Strobes low at power-up: the first write-strobe rise is no command.
// [RL12] After power-up the flash reads its array with no command.
// [RL13] Elevated level on the reset pin treats protected sectors as unprotected.
// [RL14] Removing that level protects the formerly protected sectors again.
// [RL15] A wrong value or sequence returns the flash to reading the array.
// [RL16] The flash takes the address at the later falling strobe edge.
// [RL17] The flash takes the data at the earlier rising strobe edge.
// [RL18] A finished program or erase returns the flash to reading the array; the model keeps its earlier reading mode, identification included.
// [RL19] Under erase suspend, suspended sectors read status, others read array.
// [RL20] A program under erase suspend returns to that same suspended reading.
// [RL21] After the timeout flag or identification, only the reset command restores array reads; the model also leaves identification on any out-of-sequence write.
// [RL22] Command identification: low address 00h maker, 01h part, 03h continuation.
// [RL23] A low reset pulse aborts, floats outputs and returns to array reads.
// [RL24] Upper data byte reads zero for codes that define none.
package flash_host_pkg;
  localparam int CLK_NS      = 10;
  localparam int T_GLITCH_NS = 5;
  localparam int T_WP_NS     = 30;
  localparam int T_ACC_NS    = 100;
  localparam int T_RP_NS     = 500;
  localparam int T_RH_NS     = 50;
  // Least times round up to whole cycles
  localparam int WP_CYC  = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC  = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RH_CYC  = (T_RH_NS + CLK_NS - 1) / CLK_NS;

  localparam int CNT_W  = 8;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam logic [CNT_W-1:0] WP_LOAD  = CNT_W'(WP_CYC - 1);
  localparam logic [CNT_W-1:0] ACC_LOAD = CNT_W'(ACC_CYC - 1);
  localparam logic [CNT_W-1:0] RP_LOAD  = CNT_W'(RP_CYC - 1);
  localparam logic [CNT_W-1:0] RH_LOAD  = CNT_W'(RH_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_MAX  = 8'hff;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_CMD    = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA  = 8'h14;

  // Field positions and the control register reset value
  localparam int CTRL_ID_VID  = 0;
  localparam int CTRL_RST_VID = 1;
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_SEL_LSB  = 4;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_REFUSED = 1;
  localparam int SECT_LSB     = 12;
  localparam int CODE_BIT_SIX = 6;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_ID_READ, OP_RESET} op_e;
  typedef enum logic [2:0] {ST_IDLE, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD,
                            ST_RD_WAIT, ST_RST_PULSE, ST_RST_RECOVER} state_e;
endpackage

// ===== rtl/flash_host_ctl.sv
// Flash bus controller: AHB-Lite register slave that runs single flash
// read, write, identification and reset-pulse cycles on the flash pins.
// Assumes flash inputs synchronous to clk and an external pad for the data bus.
`timescale 1ns/1ps
module flash_host_ctl (
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst_b,
  // AHB-Lite slave
  input  wire logic                                hsel,
  input  wire logic [31:0]                         haddr,
  input  wire logic [1:0]                          htrans,
  input  wire logic                                hwrite,
  input  wire logic [2:0]                          hsize,
  input  wire logic [31:0]                         hwdata,
  input  wire logic                                hready,
  output logic      [31:0]                         hrdata,
  output logic                                     hreadyout,
  output logic                                     hresp,
  // Flash pins
  output logic      [flash_host_pkg::ADDR_W-1:0]   flash_addr,
  output logic      [flash_host_pkg::DATA_W-1:0]   dq_out,
  output logic                                     dq_oe,
  input  wire logic [flash_host_pkg::DATA_W-1:0]   dq_in,
  output logic                                     ce_b,
  output logic                                     oe_b,
  output logic                                     we_b,
  output logic                                     flash_reset_b,
  output logic                                     reset_vid_en,
  output logic                                     id_vid_en
);
  import flash_host_pkg::*;

  state_e              state, next_state;
  op_e                 op, next_op;
  logic [CNT_W-1:0]    cnt, next_cnt;
  logic [1:0]          ctrl, next_ctrl;
  logic [1:0]          sel, next_sel;
  logic [ADDR_W-1:0]   addr_reg, next_addr_reg;
  logic [DATA_W-1:0]   wdata, next_wdata;
  logic [DATA_W-1:0]   rdata, next_rdata;
  logic                refused, next_refused;
  logic                wr_pend, next_wr_pend;
  logic [7:0]          wr_off, next_wr_off;
  logic [31:0]         next_hrdata;
  logic [ADDR_W-1:0]   next_flash_addr;
  logic [DATA_W-1:0]   next_dq_out;
  logic                next_dq_oe, next_ce_b, next_oe_b, next_we_b;
  logic                next_flash_reset_b, next_reset_vid_en, next_id_vid_en;
  logic [CNT_W-1:0]    rst_low_len, next_rst_low_len;
  logic                ap, start, set_refused, busy, wr_state;

  function automatic logic [31:0] read_reg(input logic [7:0] off, input logic [1:0] c,
                                           input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w,
                                           input op_e o, input logic [1:0] s, input logic b,
                                           input logic r, input logic [DATA_W-1:0] d);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (off)
      REG_CTRL:   v[1:0] = c;
      REG_ADDR:   v[ADDR_W-1:0] = a;
      REG_WDATA:  v[DATA_W-1:0] = w;
      REG_CMD:    v = {26'h0, s, 2'h0, o};
      REG_STATUS: v = {30'h0, r, b};
      REG_RDATA:  v[DATA_W-1:0] = d;
      default:    v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  assign busy = (state != ST_IDLE);

  always_comb begin
    next_state       = state;
    next_op          = op;
    next_cnt         = cnt;
    next_ctrl        = ctrl;
    next_sel         = sel;
    next_addr_reg    = addr_reg;
    next_wdata       = wdata;
    next_rdata       = rdata;
    next_refused     = refused;
    next_hrdata      = hrdata;
    next_flash_addr  = flash_addr;
    next_dq_out      = dq_out;
    start            = 1'b0;
    set_refused      = 1'b0;
    ap               = hsel && hready && htrans[1];
    next_wr_pend     = ap && hwrite;
    next_wr_off      = ap ? haddr[7:0] : wr_off;
    if (ap && !hwrite) begin
      next_hrdata = read_reg(haddr[7:0], ctrl, addr_reg, wdata, op, sel, busy, refused, rdata);
    end
    if (wr_pend) begin
      case (wr_off)
        REG_CTRL:   next_ctrl = hwdata[1:0];
        REG_ADDR:   next_addr_reg = hwdata[ADDR_W-1:0];
        REG_WDATA:  next_wdata = hwdata[DATA_W-1:0];
        REG_CMD: begin
          // A command while busy is dropped, never queued
          if (!busy) begin
            start    = 1'b1;
            next_op  = op_e'(hwdata[CMD_OP_LSB +: 2]);
            next_sel = hwdata[CMD_SEL_LSB +: 2];
          end else begin
            set_refused = 1'b1;
          end
        end
        REG_STATUS: begin
          if (hwdata[STAT_REFUSED]) begin
            next_refused = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Set after clear so a refusal in the clearing cycle survives
    if (set_refused) begin
      next_refused = 1'b1;
    end

    case (state)
      ST_IDLE: begin
        if (start) begin
          case (next_op)
            OP_READ: begin
              next_state      = ST_RD_WAIT;
              next_cnt        = ACC_LOAD;
              next_flash_addr = addr_reg;
            end
            OP_ID_READ: begin
              next_state      = ST_RD_WAIT;
              next_cnt        = ACC_LOAD;
              // Sector on the high bits, bit six low, code in bits one and zero  see [RL3] see [RL4]
              next_flash_addr = {addr_reg[ADDR_W-1:SECT_LSB], addr_reg[SECT_LSB-1:CODE_BIT_SIX+1],
                                 1'b0, addr_reg[CODE_BIT_SIX-1:2], next_sel};
            end
            OP_WRITE: begin
              // Address settles a cycle before the strobe falls  see [RL16]
              next_state      = ST_WR_SETUP;
              next_flash_addr = addr_reg;
              next_dq_out     = wdata;
            end
            OP_RESET: begin
              next_state = ST_RST_PULSE;
              next_cnt   = RP_LOAD;
            end
            default: next_state = ST_IDLE;
          endcase
        end
      end
      ST_WR_SETUP: begin
        next_state = ST_WR_PULSE;
        next_cnt   = WP_LOAD;
      end
      ST_WR_PULSE: begin
        // Pulse of whole cycles, well above the glitch filter  see [RL9]
        if (cnt == '0) begin
          next_state = ST_WR_HOLD;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_WR_HOLD: next_state = ST_IDLE;
      ST_RD_WAIT: begin
        if (cnt == '0) begin
          // Full word kept; identification codes arrive on the low byte  see [RL1] see [RL24]
          next_rdata = dq_in;
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_RST_PULSE: begin
        // Held low for the least pulse, then the recovery time  see [RL23]
        if (cnt == '0) begin
          next_state = ST_RST_RECOVER;
          next_cnt   = RH_LOAD;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_RST_RECOVER: begin
        if (cnt == '0) begin
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: next_state = ST_IDLE;
    endcase

    wr_state           = (next_state == ST_WR_SETUP) || (next_state == ST_WR_PULSE) ||
                         (next_state == ST_WR_HOLD);
    // Write strobe low only inside chip-select, with output-enable high  see [RL10]
    next_ce_b          = !(wr_state || (next_state == ST_RD_WAIT));
    next_oe_b          = (next_state != ST_RD_WAIT);
    next_we_b          = (next_state != ST_WR_PULSE);
    // Data held through the rising strobe and one cycle after  see [RL17]
    next_dq_oe         = wr_state;
    next_flash_reset_b = (next_state != ST_RST_PULSE);
    // Temporary unprotect level; software runs the protect-all step first  see [RL13] see [RL14] see [RL7]
    next_reset_vid_en  = next_ctrl[CTRL_RST_VID] && (next_state != ST_RST_PULSE);
    // Strapped identification level spans the whole read  see [RL2]
    next_id_vid_en     = next_ctrl[CTRL_ID_VID] || ((next_state == ST_RD_WAIT) && (next_op == OP_ID_READ));
    next_rst_low_len   = flash_reset_b ? '0 : ((rst_low_len == CNT_MAX) ? CNT_MAX : rst_low_len + 1'b1);
  end

  // Strobes come out of reset high, so no spurious first rise  see [RL11] see [RL12]
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state         <= ST_IDLE;
      op            <= OP_READ;
      cnt           <= '0;
      ctrl          <= CTRL_RESET;
      sel           <= 2'h0;
      addr_reg      <= '0;
      wdata         <= '0;
      rdata         <= '0;
      refused       <= 1'b0;
      wr_pend       <= 1'b0;
      wr_off        <= 8'h00;
      hrdata        <= 32'h0000_0000;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      flash_addr    <= '0;
      dq_out        <= '0;
      dq_oe         <= 1'b0;
      ce_b          <= 1'b1;
      oe_b          <= 1'b1;
      we_b          <= 1'b1;
      flash_reset_b <= 1'b1;
      reset_vid_en  <= 1'b0;
      id_vid_en     <= 1'b0;
      rst_low_len   <= '0;
    end else begin
      state         <= next_state;
      op            <= next_op;
      cnt           <= next_cnt;
      ctrl          <= next_ctrl;
      sel           <= next_sel;
      addr_reg      <= next_addr_reg;
      wdata         <= next_wdata;
      rdata         <= next_rdata;
      refused       <= next_refused;
      wr_pend       <= next_wr_pend;
      wr_off        <= next_wr_off;
      hrdata        <= next_hrdata;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      flash_addr    <= next_flash_addr;
      dq_out        <= next_dq_out;
      dq_oe         <= next_dq_oe;
      ce_b          <= next_ce_b;
      oe_b          <= next_oe_b;
      we_b          <= next_we_b;
      flash_reset_b <= next_flash_reset_b;
      reset_vid_en  <= next_reset_vid_en;
      id_vid_en     <= next_id_vid_en;
      rst_low_len   <= next_rst_low_len;
    end
  end

  sequence s_we_low;
    (!we_b && !ce_b && oe_b && dq_oe) [*3];
  endsequence
  sequence s_we_release;
    we_b && !ce_b && dq_oe ##1 ce_b && !dq_oe;
  endsequence

  property p_write_qual;
    @(posedge clk) disable iff (!rst_b) !we_b |-> (!ce_b && oe_b);
  endproperty
  a_write_qual: assert property (p_write_qual) else $error("write strobe low outside a qualified write"); // see [RL10]

  property p_we_pulse;
    @(posedge clk) disable iff (!rst_b) $fell(we_b) |-> s_we_low ##1 s_we_release;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe pulse has wrong shape"); // see [RL9]

  property p_addr_before_we;
    @(posedge clk) disable iff (!rst_b) $fell(we_b) |-> !$past(ce_b) && $stable(flash_addr);
  endproperty
  a_addr_before_we: assert property (p_addr_before_we) else $error("address not settled before strobe fall"); // see [RL16]

  property p_data_at_rise;
    @(posedge clk) disable iff (!rst_b) $rose(we_b) |-> dq_oe && $stable(dq_out) && $stable(flash_addr);
  endproperty
  a_data_at_rise: assert property (p_data_at_rise) else $error("data moved at strobe rise"); // see [RL17]

  property p_id_strap;
    @(posedge clk) disable iff (!rst_b) (!oe_b && op == OP_ID_READ) |->
      id_vid_en && !flash_addr[CODE_BIT_SIX] && (flash_addr[1:0] == sel);
  endproperty
  a_id_strap: assert property (p_id_strap) else $error("identification read without strap setup"); // see [RL2]

  property p_sector_kept;
    @(posedge clk) disable iff (!rst_b) (!oe_b && op == OP_ID_READ) |->
      (flash_addr[ADDR_W-1:SECT_LSB] == addr_reg[ADDR_W-1:SECT_LSB]);
  endproperty
  a_sector_kept: assert property (p_sector_kept) else $error("sector address missing on query"); // see [RL4]

  property p_read_len;
    @(posedge clk) disable iff (!rst_b) $fell(oe_b) |->
      (!oe_b && !ce_b && !dq_oe) [*8] ##1 !oe_b [*2] ##1 (oe_b && ce_b);
  endproperty
  a_read_len: assert property (p_read_len) else $error("read cycle length wrong"); // see [RL1]

  property p_reset_pulse;
    @(posedge clk) disable iff (!rst_b) $rose(flash_reset_b) |-> (rst_low_len == CNT_W'(RP_CYC)) && we_b && ce_b;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse length wrong"); // see [RL23]

  property p_no_vid_in_reset;
    @(posedge clk) disable iff (!rst_b) !flash_reset_b |-> !reset_vid_en;
  endproperty
  a_no_vid_in_reset: assert property (p_no_vid_in_reset) else $error("elevated level during reset pulse"); // see [RL13]

  property p_refused;
    @(posedge clk) disable iff (!rst_b) (wr_pend && wr_off == REG_CMD && busy) |=> refused && $stable(op);
  endproperty
  a_refused: assert property (p_refused) else $error("busy command not flagged");

  property p_ahb_okay;
    @(posedge clk) disable iff (!rst_b) hreadyout && !hresp;
  endproperty
  a_ahb_okay: assert property (p_ahb_okay) else $error("slave stalled or errored");
endmodule

// ===== tb/flash_dev_model.sv
// Behavioural x16 flash seen from its pins: array, unlock commands, codes, sector protection.
// Assumes one clocked controller drives the pins; embedded algorithms finish at once.
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [7:0] MAKER_CODE = 8'h01,  // Arbitrary value
  parameter logic [7:0] PART_LO    = 8'h02,  // Arbitrary value
  parameter logic [7:0] PART_HI    = 8'h03,  // Arbitrary value
  parameter logic [7:0] CONT_CODE  = 8'h04   // Arbitrary value
) (
  // Address and data
  input  wire logic [18:0] addr,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata,
  // Strobes and elevated-level controls
  input  wire logic        ce_b,
  input  wire logic        oe_b,
  input  wire logic        we_b,
  input  wire logic        reset_b,
  input  wire logic        reset_vid,
  input  wire logic        id_vid
);
  logic [15:0] mem [logic [18:0]];
  logic        prot [0:127];
  logic [1:0]  phase;
  logic        id_mode, prog_next, armed;
  logic [18:0] lat_a;
  logic [15:0] last;
  realtime     t_fall;
  initial begin
    foreach (prot[i]) prot[i] = 1'b0;
    phase = 2'd0;
    id_mode = 1'b0;
    prog_next = 1'b0;
    armed = 1'b0;
    last = 16'h0;
  end
  function automatic logic [15:0] arr(input logic [18:0] a);
    return mem.exists(a) ? mem[a] : (a[15:0] ^ 16'h5a5a);
  endfunction
  function automatic logic [15:0] idcode(input logic [18:0] a);
    case (a[1:0])
      2'd0: return {8'h00, MAKER_CODE};
      2'd1: return {PART_HI, PART_LO};
      2'd3: return {8'h00, CONT_CODE};
      default: return {15'h0000, prot[a[18:12]]};
    endcase
  endfunction
  task automatic take(input logic [18:0] a, input logic [15:0] d);
    if (prog_next) begin
      if (!prot[a[18:12]] || reset_vid) mem[a] = d;
      // Reading mode is left as it was before the program
      prog_next = 1'b0;
    end else if (d[7:0] == 8'hf0) begin
      phase = 2'd0;
      id_mode = 1'b0;
    end else if (phase == 2'd0 && a[10:0] == 11'h555 && d[7:0] == 8'haa) phase = 2'd1;
    else if (phase == 2'd1 && a[10:0] == 11'h2aa && d[7:0] == 8'h55) phase = 2'd2;
    else if (phase == 2'd2 && a[10:0] == 11'h555 && d[7:0] == 8'h90) begin
      phase = 2'd0;
      id_mode = 1'b1;
    end else if (phase == 2'd2 && a[10:0] == 11'h555 && d[7:0] == 8'ha0) begin
      phase = 2'd0;
      prog_next = 1'b1;
    end else begin
      phase = 2'd0;
      id_mode = 1'b0;
    end
  endtask
  always @(negedge reset_b) begin
    phase = 2'd0;
    id_mode = 1'b0;
    prog_next = 1'b0;
    armed = 1'b0;
  end
  // Strobe levels at power-up never arm a write; only a later fall does
  always @(negedge we_b or negedge ce_b)
    if ($realtime > 0 && !we_b && !ce_b && oe_b && reset_b) begin
      lat_a = addr;
      t_fall = $realtime;
      armed = 1'b1;
    end
  always @(posedge we_b or posedge ce_b)
    if (armed) begin
      armed = 1'b0;
      if ($realtime - t_fall >= 5.0) take(lat_a, wdata);
    end
  // Undriven bus shows the inverse of the last word, never a stale copy
  always @* begin
    if (reset_b && !ce_b && !oe_b) begin
      rdata = (id_vid || id_mode) ? idcode(addr) : arr(addr);
      last = rdata;
    end else rdata = ~last;
  end
endmodule

// ===== tb/tb_flash_host_ctl.sv
// Self-checking bench: AHB-Lite master, flash model on the pins, random and corner cases.
// Assumes the controller and model of this code base; one clock domain.
`timescale 1ns/1ps
module tb_flash_host_ctl;
  import flash_host_pkg::*;
  localparam logic [7:0] MAKER = 8'h2c;  // Arbitrary value
  localparam logic [7:0] P_LO  = 8'h4d;  // Arbitrary value
  localparam logic [7:0] P_HI  = 8'h5e;  // Arbitrary value
  localparam logic [7:0] CONT  = 8'h6e;  // Arbitrary value
  logic        clk, rst_b, hsel, hwrite, hreadyout, hresp, dq_oe;
  logic        ce_b, oe_b, we_b, flash_reset_b, reset_vid_en, id_vid_en;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [18:0] flash_addr, a, pa;
  logic [15:0] dq_out, dq_in, dev_q, d, v;
  int          err_total, checks_done, cycles;
  assign dq_in = dq_oe ? dq_out : dev_q;
  flash_host_ctl dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .ce_b(ce_b), .oe_b(oe_b),
    .we_b(we_b), .flash_reset_b(flash_reset_b), .reset_vid_en(reset_vid_en), .id_vid_en(id_vid_en));
  flash_dev_model #(.MAKER_CODE(MAKER), .PART_LO(P_LO), .PART_HI(P_HI), .CONT_CODE(CONT)) flash (
    .addr(flash_addr), .wdata(dq_out), .rdata(dev_q), .ce_b(ce_b), .oe_b(oe_b), .we_b(we_b),
    .reset_b(flash_reset_b), .reset_vid(reset_vid_en), .id_vid(id_vid_en));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // A hung handshake ends here rather than running forever
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] ra, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, ra};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] ra, input logic [31:0] wd);
    logic [31:0] x;
    ahb(1'b1, ra, wd, x);
  endtask
  task automatic rd(input logic [7:0] ra, output logic [31:0] q);
    ahb(1'b0, ra, 32'h0, q);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rd(REG_STATUS, r);
      n++;
    end while (r[STAT_BUSY] !== 1'b0 && n < 100);
    check({31'h0, r[STAT_BUSY]}, 32'h0);
  endtask
  task automatic op(input op_e o, input logic [18:0] fa, input logic [15:0] fd, input logic [1:0] s);
    wr(REG_ADDR, {13'h0, fa});
    wr(REG_WDATA, {16'h0, fd});
    wr(REG_CMD, {26'h0, s, 2'b00, o});
    wait_idle();
  endtask
  task automatic cmd(input logic [18:0] fa, input logic [15:0] fd);
    op(OP_WRITE, fa, fd, 2'b00);
  endtask
  task automatic fread(input logic [18:0] fa, output logic [15:0] q);
    op(OP_READ, fa, 16'h0, 2'b00);
    rd(REG_RDATA, r);
    q = r[15:0];
  endtask
  task automatic unlock(input logic [15:0] c);
    cmd(19'h555, 16'h00aa);
    cmd(19'h2aa, 16'h0055);
    cmd(19'h555, c);
  endtask
  task automatic prog_word(input logic [18:0] fa, input logic [15:0] fd);
    unlock(16'h00a0);
    cmd(fa, fd);
  endtask
  function automatic logic [15:0] exp_id(input logic [1:0] s, input logic p);
    case (s)
      2'd0: return {8'h00, MAKER};
      2'd1: return {P_HI, P_LO};
      2'd2: return {15'h0000, p};
      default: return {8'h00, CONT};
    endcase
  endfunction
  initial begin
    rst_b = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    void'($urandom(32'h15cd_a7ca));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    check({25'h0, ce_b, oe_b, we_b, flash_reset_b, dq_oe, id_vid_en, reset_vid_en}, 32'h78);
    rd(REG_CTRL, r);
    check(r, 32'h0);
    rd(8'h20, r);
    check({r[31:1], hresp}, 32'h0);
    a = {7'h11, 12'($urandom)};
    fread(a, v);
    check({16'h0, v}, {16'h0, a[15:0] ^ 16'h5a5a});
    repeat (6) begin
      a = {7'h11, 12'($urandom)};
      d = 16'($urandom);
      prog_word(a, d);
      fread(a, v);
      check({16'h0, v}, {16'h0, d});
    end
    pa = {7'h55, 12'($urandom)};
    d = 16'($urandom);
    prog_word(pa, d);
    flash.prot[pa[18:12]] = 1'b1;
    prog_word(pa, ~d);
    fread(pa, v);
    check({16'h0, v}, {16'h0, d});
    for (int s = 0; s < 4; s++) begin
      op(OP_ID_READ, pa, 16'h0, 2'(s));
      rd(REG_RDATA, r);
      check(r, {16'h0, exp_id(2'(s), 1'b1)});
    end
    wr(REG_CTRL, 32'h1);
    fread({pa[18:12], 12'h000}, v);
    check({16'h0, v}, {16'h0, exp_id(2'd0, 1'b1)});
    wr(REG_CTRL, 32'h0);
    unlock(16'h0090);
    for (int s = 0; s < 5; s++) begin
      fread({pa[18:12], 10'h0, 2'(s)}, v);
      check({16'h0, v}, {16'h0, exp_id(2'(s), 1'b1)});
    end
    cmd(19'h0, 16'h00f0);
    fread(pa, v);
    check({16'h0, v}, {16'h0, d});
    wr(REG_CTRL, 32'h2);
    prog_word(pa, ~d);
    check({31'h0, reset_vid_en}, 32'h1);
    wr(REG_CTRL, 32'h0);
    fread(pa, v);
    check({16'h0, v}, {16'h0, ~d});
    check({31'h0, reset_vid_en}, 32'h0);
    prog_word(pa, d);
    fread(pa, v);
    check({16'h0, v}, {16'h0, ~d});
    // Unprotect clears every sector, so all are protected first
    foreach (flash.prot[i]) flash.prot[i] = 1'b1;
    foreach (flash.prot[i]) flash.prot[i] = 1'b0;
    prog_word(pa, d);
    fread(pa, v);
    check({16'h0, v}, {16'h0, d});
    unlock(16'h0012);
    cmd(pa, ~d);
    fread(pa, v);
    check({16'h0, v}, {16'h0, d});
    unlock(16'h0090);
    wr(REG_CTRL, 32'h2);
    wr(REG_CMD, {30'h0, OP_RESET});
    wr(REG_CMD, {30'h0, OP_READ});
    repeat (10) @(posedge clk);
    check({30'h0, flash_reset_b, reset_vid_en}, 32'h0);
    wait_idle();
    wr(REG_CTRL, 32'h0);
    rd(REG_STATUS, r);
    check(r, 32'h2);
    wr(REG_STATUS, 32'h2);
    rd(REG_STATUS, r);
    check(r, 32'h0);
    fread(pa, v);
    check({16'h0, v}, {16'h0, d});
    conclude();
  end
endmodule
